// *** adc_serial_control_port_test.sv ***
// self-checking bench for the converter serial control port
`include "ascp_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module adc_serial_control_port_test
  import ascp_pkg::*;
  ;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic convertStart = 1'b0;
  logic resetIn = 1'b0;
  logic powerDownIn = 1'b0;
  logic [15:0] convResult = 16'h0000;
  logic sck, chipSelectN, configDataIn, resultSerialOut, resultOutEn, busy, lowBias, en;
  ascp_cfg_t cfgActive, act, pend;
  logic [31:0] lfsr = 32'h0000_5e40;
  logic [31:0] snap, rd;
  bit hasPend;
  int error_cnt = 0;
  int n_checks = 0;
  int busyRun = 0;
  int busyLen = 0;
  int tn[8] = '{17, 32, 32, 11, 17, 17, 11, 32};
  int tm[8] = '{0, 0, 1, 0, 2, 3, 0, 1};

  // design and host
  ascp_serial_port i_ascp_serial_port (.sys_clk(sys_clk), .rst(rst), .sck(sck),
    .chipSelectN(chipSelectN), .configDataIn(configDataIn),
    .resultSerialOut(resultSerialOut), .resultOutEn(resultOutEn),
    .convertStart(convertStart), .resetIn(resetIn), .powerDownIn(powerDownIn),
    .busy(busy), .convResult(convResult), .cfgActive(cfgActive), .lowBias(lowBias));
  ascp_host_model i_ascp_host_model (.sck(sck), .chipSelectN(chipSelectN),
    .configDataIn(configDataIn), .resultSerialOut(resultSerialOut),
    .resultOutEn(resultOutEn));

  // 50 MHz system clock
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  // busy run length, captured when busy drops
  always @(posedge sys_clk)
  begin
    if (busy === 1'b1)
      busyRun <= busyRun + 1;
    else if (busyRun != 0)
    begin
      busyLen <= busyRun;
      busyRun <= 0;
    end
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // wait n edges, then let their updates land
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // bounded wait on busy or on the low-bias flag
  task automatic waitLvl(input bit selLow, input logic v);
    int k;
    k = 0;
    while (((selLow ? lowBias : busy) !== v) && k < 80)
    begin
      tick(1);
      k++;
    end
    if (k == 80)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic doRst();
    @(posedge sys_clk) rst <= 1'b1;
    tick(16);
    @(posedge sys_clk) rst <= 1'b0;
    act = `ASCP_CFG_DEFAULT;
    hasPend = 0;
    snap = 32'h0000_0000;
    tick(1);
    check({busy, lowBias, resultOutEn, cfgActive}, {3'b000, act});
  endtask

  // one link frame with a random word; full selected frames compare the read-back
  task automatic frame(input int n, input bit sel);
    ascp_cfg_t w;
    lfsr = nextRand(lfsr);
    w = lfsr[31:16];
    i_ascp_host_model.xfer(w, n, sel, rd, en);
    check(en, sel);
    if (n == 32 && sel)
      check(rd, snap);
    if (sel && n > 16)
    begin
      pend = w;
      hasPend = 1;
    end
    tick(8);
    check(resultOutEn, 1'b0);
  endtask

  // mode 0 plain, 1 write and extra edge while busy, 2 pin reset, 3 system reset
  task automatic conv(input int mode);
    lfsr = nextRand(lfsr);
    @(posedge sys_clk) convResult <= lfsr[15:0];
    convertStart <= 1'b1;
    waitLvl(0, 1'b1);
    @(posedge sys_clk) convertStart <= 1'b0;
    if (mode == 1)
      frame(32, 1);
    if (mode == 1)
      @(posedge sys_clk) convertStart <= 1'b1;
    if (mode == 2)
    begin
      @(posedge sys_clk) resetIn <= 1'b1;
      waitLvl(0, 1'b0);
      @(posedge sys_clk) resetIn <= 1'b0;
      act = `ASCP_CFG_DEFAULT;
      hasPend = 0;
    end
    else if (mode == 3)
      doRst();
    else
    begin
      waitLvl(0, 1'b0);
      snap = {convResult, act};
      if (hasPend)
        act = pend;
      hasPend = 0;
      check(cfgActive, act);
      tick(2);
      check(busyLen, 32'(`ASCP_CONV_CYC));
    end
    check(cfgActive, act);
    @(posedge sys_clk) convertStart <= 1'b0;
    tick(4);
    check(busy, 1'b0);
  endtask

  // main sequence
  initial
  begin
    doRst();
    frame(17, 1);
    check(cfgActive, act);
    conv(0);
    for (int i = 0; i < 8; i++)
    begin
      frame(tn[i], i != 2);
      conv(tm[i]);
    end
    @(posedge sys_clk) powerDownIn <= 1'b1;
    waitLvl(1, 1'b1);
    @(posedge sys_clk) convertStart <= 1'b1;
    tick(10);
    check(busy, 1'b0);
    @(posedge sys_clk) powerDownIn <= 1'b0;
    convertStart <= 1'b0;
    waitLvl(1, 1'b0);
    tick(20);
    conv(0);
    conv(0);
    frame(32, 1);
    summarize();
  end
endmodule

`default_nettype wire

// *** ascp_defines.svh ***
// constants for the converter serial control port
`ifndef ASCP_DEFINES_SVH
`define ASCP_DEFINES_SVH

// ----------------------------------------------------------------------
// word and counter widths
// ----------------------------------------------------------------------
`define ASCP_CFG_WIDTH 16
`define ASCP_RES_WIDTH 16
`define ASCP_FRAME_WIDTH 32
`define ASCP_RX_CNT_W 4
`define ASCP_TX_CNT_W 6

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define ASCP_CFG_DEFAULT 16'h0000
`define ASCP_RX_LAST 4'hf
`define ASCP_TX_LAST 6'h20

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ASCP_SYS_CLK_HZ 64'd50_000_000
`define ASCP_CONV_TIME_NS 64'd1000
`define ASCP_CONV_CYC ((`ASCP_CONV_TIME_NS * `ASCP_SYS_CLK_HZ) / 64'd1_000_000_000)
`define ASCP_CNT_W 6

`endif

// *** ascp_host_model.sv ***
// host-side model of the serial link: clock, select, config data, result capture
`timescale 1ns/1ns
`default_nettype none

module ascp_host_model
  import ascp_pkg::*;
(
  // link pins
  output logic sck,
  output logic chipSelectN,
  output logic configDataIn,
  // result pins from the device
  input wire logic resultSerialOut,
  input wire logic resultOutEn
);
  // idle: clock high and still, select high; late rise clears link flops under reset
  initial
  begin
    sck = 1'b0;
    chipSelectN = 1'b0;
    configDataIn = 1'b0;
    #1;
    sck = 1'b1;
    chipSelectN = 1'b1;
  end

  // n falling edges and n-1 rising ones, word msb first, 6 ns period
  task automatic xfer(input ascp_cfg_t w, input int n, input bit sel,
                      output logic [31:0] rd, output logic en);
    rd = 32'h0000_0000;
    en = 1'b0;
    chipSelectN = !sel; // independent select control
    #3;
    for (int i = 0; i < n; i++)
    begin
      sck = 1'b0;
      configDataIn = (i < 16) ? w[15-i] : !configDataIn;
      #3;
      rd[31-i] = resultSerialOut;
      if (i == 0)
        en = resultOutEn;
      if (i < n - 1)
        sck = 1'b1;
      #3;
    end
    // select rises before the clock returns high, so no extra bit
    chipSelectN = 1'b1;
    configDataIn = !configDataIn;
    #3;
    sck = 1'b1;
  endtask
endmodule

`default_nettype wire

// *** ascp_pkg.sv ***
// types shared by the converter serial control port
`include "ascp_defines.svh"
`default_nettype none

package ascp_pkg;

  // configuration word as held by the device
  typedef logic [`ASCP_CFG_WIDTH-1:0] ascp_cfg_t;

  // read frame: result first, then the configuration it was taken with
  typedef struct packed {
    logic [`ASCP_RES_WIDTH-1:0] result;
    ascp_cfg_t cfg;
  } ascp_frame_t;

  // conversion control states
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_BUSY,
    CONV_PDOWN
  } ascp_conv_state_t;

endpackage
`default_nettype wire

// *** ascp_serial_port.sv ***
// converter serial control port: config latch, conversion control, result shift-out
`include "ascp_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module ascp_serial_port
  import ascp_pkg::*;
(
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial link from host
  input wire logic sck,
  input wire logic chipSelectN,
  input wire logic configDataIn,
  output logic resultSerialOut,
  output logic resultOutEn,
  // control pins from host
  input wire logic convertStart,
  input wire logic resetIn,
  input wire logic powerDownIn,
  output logic busy,
  // conversion engine side
  input wire logic [`ASCP_RES_WIDTH-1:0] convResult,
  output ascp_cfg_t cfgActive,
  output logic lowBias
);

  localparam int ConvMax = int'(`ASCP_CONV_CYC) + 1;

  // ----------------------------------------------------------------------
  // link side: config shift-in on rising serial clock
  // ----------------------------------------------------------------------
  logic [`ASCP_RX_CNT_W-1:0] rxCnt_r;
  logic [`ASCP_RX_CNT_W-1:0] rxCnt_nxt;
  ascp_cfg_t rxShift_r;
  ascp_cfg_t rxShift_nxt;
  ascp_cfg_t rxHold_r;
  ascp_cfg_t rxHold_nxt;
  logic rxTog_r;
  logic rxTog_nxt;

  // next bit count, shift, and completed word
  always_comb
  begin
    rxShift_nxt = {rxShift_r[`ASCP_CFG_WIDTH-2:0], configDataIn};
    rxCnt_nxt = rxCnt_r + 4'h1;
    rxHold_nxt = rxHold_r;
    rxTog_nxt = rxTog_r;
    if (rxCnt_r == `ASCP_RX_LAST)
    begin
      rxHold_nxt = rxShift_nxt;
      rxTog_nxt = ~rxTog_r;
    end
  end

  // bit count restarts whenever chip select is high
  always_ff @(posedge sck or posedge chipSelectN or posedge rst)
  begin
    if (rst || chipSelectN)
    begin
      rxCnt_r <= 4'h0;
      rxShift_r <= 16'h0000;
    end
    else
    begin
      rxCnt_r <= rxCnt_nxt;
      rxShift_r <= rxShift_nxt;
    end
  end

  // completed word and its toggle survive the end of the frame
  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
    begin
      rxHold_r <= 16'h0000;
      rxTog_r <= 1'b0;
    end
    else if (!chipSelectN)
    begin
      rxHold_r <= rxHold_nxt;
      rxTog_r <= rxTog_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // link side: result shift-out on falling serial clock
  // ----------------------------------------------------------------------
  ascp_frame_t snap_r;
  logic [`ASCP_TX_CNT_W-1:0] txCnt_r;
  logic [`ASCP_TX_CNT_W-1:0] txCnt_nxt;
  logic [`ASCP_FRAME_WIDTH-1:0] txShift_r;
  logic [`ASCP_FRAME_WIDTH-1:0] txShift_nxt;
  logic resultSerialOut_r;
  logic resultSerialOut_nxt;
  logic resultOutEn_r;

  // first edge loads the snapshot, later edges shift, then zeros
  always_comb
  begin
    txCnt_nxt = txCnt_r;
    txShift_nxt = {txShift_r[`ASCP_FRAME_WIDTH-2:0], 1'b0};
    resultSerialOut_nxt = txShift_r[`ASCP_FRAME_WIDTH-1];
    if (txCnt_r == 6'h00)
    begin
      // snapshot is quiet outside end of conversion
      txShift_nxt = {snap_r[`ASCP_FRAME_WIDTH-2:0], 1'b0};
      resultSerialOut_nxt = snap_r[`ASCP_FRAME_WIDTH-1];
    end
    if (txCnt_r != `ASCP_TX_LAST)
      txCnt_nxt = txCnt_r + 6'h01;
    else
      resultSerialOut_nxt = 1'b0;
  end

  // output floats while chip select is high
  always_ff @(negedge sck or posedge chipSelectN or posedge rst)
  begin
    if (rst || chipSelectN)
    begin
      txCnt_r <= 6'h00;
      txShift_r <= 32'h0000_0000;
      resultSerialOut_r <= 1'b0;
      resultOutEn_r <= 1'b0;
    end
    else
    begin
      txCnt_r <= txCnt_nxt;
      txShift_r <= txShift_nxt;
      resultSerialOut_r <= resultSerialOut_nxt;
      resultOutEn_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // system side: pin and toggle synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] syncOut;
  logic [2:0] prev_r;
  logic [2:0] prev_nxt;
  logic cnvEdge;
  logic pinResetEdge;
  logic pdEdge;
  logic pdLevel;
  logic rxNew;
  logic ackTog_r;

  ascp_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .clk(sys_clk),
    .rst(rst),
    .asyncIn({rxTog_r, powerDownIn, resetIn, convertStart}),
    .syncOut(syncOut)
  );

  // edge detection on the synchronised levels
  always_comb
  begin
    prev_nxt = syncOut[2:0];
    cnvEdge = syncOut[0] & ~prev_r[0];
    pinResetEdge = syncOut[1] & ~prev_r[1];
    pdEdge = syncOut[2] & ~prev_r[2];
    pdLevel = syncOut[2];
    rxNew = syncOut[3] ^ ackTog_r;
  end

  // ----------------------------------------------------------------------
  // system side: conversion control
  // ----------------------------------------------------------------------
  ascp_conv_state_t state_r;
  ascp_conv_state_t state_nxt;
  logic [`ASCP_CNT_W-1:0] convCnt_r;
  logic [`ASCP_CNT_W-1:0] convCnt_nxt;
  ascp_cfg_t cfgActive_r;
  ascp_cfg_t cfgActive_nxt;
  ascp_cfg_t cfgPending_r;
  ascp_cfg_t cfgPending_nxt;
  logic pendValid_r;
  logic pendValid_nxt;
  ascp_frame_t snap_nxt;
  logic busy_r;
  logic busy_nxt;
  logic lowBias_r;
  logic lowBias_nxt;
  logic ackTog_nxt;
  logic eoc;

  // next state of conversion, config and power-down
  always_comb
  begin
    state_nxt = state_r;
    convCnt_nxt = convCnt_r;
    cfgActive_nxt = cfgActive_r;
    cfgPending_nxt = cfgPending_r;
    pendValid_nxt = pendValid_r;
    snap_nxt = snap_r;
    busy_nxt = busy_r;
    lowBias_nxt = lowBias_r;
    ackTog_nxt = ackTog_r;
    eoc = 1'b0;
    if (pinResetEdge)
    begin
      state_nxt = CONV_IDLE;
      busy_nxt = 1'b0;
      lowBias_nxt = 1'b0;
      convCnt_nxt = 6'h00;
      cfgActive_nxt = `ASCP_CFG_DEFAULT;
      pendValid_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        CONV_IDLE:
        begin
          if (pdEdge)
          begin
            state_nxt = CONV_PDOWN;
            lowBias_nxt = 1'b1;
          end
          else if (cnvEdge)
          begin
            state_nxt = CONV_BUSY;
            busy_nxt = 1'b1;
            convCnt_nxt = `ASCP_CNT_W'(`ASCP_CONV_CYC - 64'd1);
          end
        end
        CONV_BUSY:
        begin
          if (pdEdge)
          begin
            state_nxt = CONV_PDOWN;
            busy_nxt = 1'b0;
            lowBias_nxt = 1'b1;
          end
          else if (convCnt_r == 6'h00)
          begin
            eoc = 1'b1;
            state_nxt = CONV_IDLE;
            busy_nxt = 1'b0;
            snap_nxt = '{result: convResult, cfg: cfgActive_r};
            if (pendValid_r)
            begin
              cfgActive_nxt = cfgPending_r;
              pendValid_nxt = 1'b0;
            end
          end
          else
            convCnt_nxt = convCnt_r - 6'h01;
        end
        CONV_PDOWN:
        begin
          if (!pdLevel)
          begin
            state_nxt = CONV_IDLE;
            lowBias_nxt = 1'b0;
          end
        end
      endcase
    end
    // a new word wins over the clear in the same cycle
    if (rxNew)
    begin
      ackTog_nxt = ~ackTog_r;
      cfgPending_nxt = rxHold_r;
      pendValid_nxt = 1'b1;
    end
  end

  // register conversion control
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prev_r <= 3'h0;
      state_r <= CONV_IDLE;
      convCnt_r <= 6'h00;
      cfgActive_r <= `ASCP_CFG_DEFAULT;
      cfgPending_r <= `ASCP_CFG_DEFAULT;
      pendValid_r <= 1'b0;
      snap_r <= 32'h0000_0000;
      busy_r <= 1'b0;
      lowBias_r <= 1'b0;
      ackTog_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      state_r <= state_nxt;
      convCnt_r <= convCnt_nxt;
      cfgActive_r <= cfgActive_nxt;
      cfgPending_r <= cfgPending_nxt;
      pendValid_r <= pendValid_nxt;
      snap_r <= snap_nxt;
      busy_r <= busy_nxt;
      lowBias_r <= lowBias_nxt;
      ackTog_r <= ackTog_nxt;
    end
  end

  // outputs straight from flops
  assign busy = busy_r;
  assign cfgActive = cfgActive_r;
  assign lowBias = lowBias_r;
  assign resultSerialOut = resultSerialOut_r;
  assign resultOutEn = resultOutEn_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence sConvStart;
    cnvEdge && state_r == CONV_IDLE && !pdEdge && !pinResetEdge;
  endsequence

  sequence sQuiet;
    (!pinResetEdge && !pdEdge)[*8];
  endsequence

  sequence sConvEnd;
    eoc && pendValid_r;
  endsequence

  a_conv_start: assert property (sConvStart |=> busy_r)
    else $error("busy did not rise after convert start");
  a_busy_span: assert property (sConvStart ##1 sQuiet |=> busy_r)
    else $error("busy fell too early");
  a_busy_end: assert property (sConvStart |-> ##[1:ConvMax] !busy_r)
    else $error("conversion did not end in time");
  a_cfg_apply: assert property (sConvEnd |=> cfgActive_r == $past(cfgPending_r))
    else $error("pending config not applied at end of conversion");
  a_cfg_hold: assert property (!eoc && !pinResetEdge |=> $stable(cfgActive_r))
    else $error("active config changed outside end of conversion");
  a_reset_abort: assert property (pinResetEdge |=> !busy_r && cfgActive_r == `ASCP_CFG_DEFAULT)
    else $error("reset pin did not abort and restore config");
  a_pd_enter: assert property (pdEdge && !pinResetEdge |=> lowBias_r && !busy_r)
    else $error("power-down edge did not enter low bias");
  a_cfg_take: assert property (rxNew |=> pendValid_r && cfgPending_r == $past(rxHold_r))
    else $error("shifted config word not taken");
  a_sdo_float: assert property (chipSelectN |-> !resultOutEn_r)
    else $error("result output driven with chip select high");
  a_rx_shift: assert property (@(posedge sck) disable iff (rst || chipSelectN)
    rxCnt_r < `ASCP_RX_LAST |=> rxShift_r[0] == $past(configDataIn))
    else $error("config bit not sampled on rising edge");
  a_tx_shift: assert property (@(negedge sck) disable iff (rst || chipSelectN)
    txCnt_r != 6'h00 && txCnt_r < `ASCP_TX_LAST |=> resultSerialOut_r == $past(txShift_r[31]))
    else $error("result bit not shifted on falling edge");

endmodule
`default_nettype wire

// *** ascp_sync2.sv ***
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
`default_nettype none

module ascp_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage1_nxt;
  logic [WIDTH-1:0] stage2_nxt;

  // next values: first stage feeds only the second
  always_comb
  begin
    stage1_nxt = asyncIn;
    stage2_nxt = stage1_r;
  end

  // register stages
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1_r <= '0;
      stage2_r <= '0;
    end
    else
    begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign syncOut = stage2_r;

endmodule
`default_nettype wire
